// >>> include/lps_pkg.sv
// Purpose: Shared constants and types for the lookup-table pair sequential element
// Assumes: APB register access, 32-bit data, one aligned word per register
// Notes:   All offsets are byte addresses
package lps_pkg;

  localparam int LPS_ADDR_W = 8;
  localparam int LPS_DATA_W = 32;

  // Register byte offsets
  localparam logic [LPS_ADDR_W-1:0] LPS_OFS_SEQ_CTRL = 8'h00;
  localparam logic [LPS_ADDR_W-1:0] LPS_OFS_TBL_CTRL = 8'h04;
  localparam logic [LPS_ADDR_W-1:0] LPS_OFS_STATUS   = 8'h08;

  // Field positions
  localparam int LPS_SEL_LSB      = 0;
  localparam int LPS_SEL_MSB      = 1;
  localparam int LPS_EN_BIT       = 0;
  localparam int LPS_STAT_Q_BIT   = 0;
  localparam int LPS_STAT_RST_BIT = 1;
  localparam int LPS_STAT_EN_BIT  = 2;

  localparam logic [LPS_DATA_W-1:0] LPS_ZERO_WORD = 32'h0000_0000;

  // Sequential type select encodings, in field order
  typedef enum logic [1:0] {
    LPS_MODE_DFF,
    LPS_MODE_JK,
    LPS_MODE_DLATCH,
    LPS_MODE_RS
  } lps_mode_e;

  typedef struct packed {
    lps_mode_e               mode;
    logic                    even_en;
    logic                    gclk_d;
    logic                    q;
    logic                    rst_req;
    logic [LPS_DATA_W-1:0]   prdata;
  } lps_state_s;

  localparam lps_state_s LPS_STATE_RST = '{
    mode:    LPS_MODE_DFF,
    even_en: 1'b0,
    gclk_d:  1'b0,
    q:       1'b0,
    rst_req: 1'b0,
    prdata:  32'h0000_0000
  };

endpackage : lps_pkg

// >>> src/lps_seq_next.sv
// Purpose: Next output value of the sequential element for each selected type
// Assumes: Called once per ref_clk cycle with the generic clock rising edge already detected
// Notes:   Purely combinational; the owner holds the state
`timescale 1ns/10ps
module lps_seq_next (
  input  wire lps_pkg::lps_mode_e mode,
  input  wire logic               even_in,
  input  wire logic               odd_in,
  input  wire logic               q,
  input  wire logic               clk_rise,
  input  wire logic               clear,
  output logic                    q_nxt
);

  always_comb
  begin
    q_nxt = q;
    if (clear)
    begin
      q_nxt = 1'b0;
    end
    else
    begin
      case (mode)
        lps_pkg::LPS_MODE_DFF:
        begin
          if (clk_rise && odd_in)
          begin
            q_nxt = even_in;
          end
        end
        lps_pkg::LPS_MODE_JK:
        begin
          if (clk_rise)
          begin
            case ({even_in, odd_in})
              2'h2:    q_nxt = 1'b1;
              2'h1:    q_nxt = 1'b0;
              2'h3:    q_nxt = ~q;
              default: q_nxt = q;
            endcase
          end
        end
        lps_pkg::LPS_MODE_DLATCH:
        begin
          // Transparent while the gate is high, sampled at ref_clk rate
          if (odd_in)
          begin
            q_nxt = even_in;
          end
        end
        default:
        begin
          // Both set and reset high holds, avoiding a race toward either value
          if (even_in && !odd_in)
          begin
            q_nxt = 1'b1;
          end
          else if (odd_in && !even_in)
          begin
            q_nxt = 1'b0;
          end
        end
      endcase
    end
  end

endmodule : lps_seq_next

// >>> src/lps_seq_element.sv
// Purpose: Sequential stage behind one lookup-table pair, configured over APB
// Assumes: All inputs synchronous to ref_clk; generic clock sampled as a level
// Notes:   Output is gated by the even table enable so a disable clears it at once
//
// Summary of operation
// - A selection field picks a gated D flip-flop, JK flip-flop, gated D-latch or RS-latch.
// - In D flip-flop mode data comes from the even table output and the gate from the odd one.
// - While the even table is disabled the output is cleared without waiting for a clock edge.
// - The internal reset request to the flip-flop lasts exactly one bus clock cycle.
// - Without reset, the flip-flop output changes only on rising generic clock edges.
// - Reset clears, gate high loads data, gate low holds.
// - In JK mode J comes from the even table output and K from the odd one.
`timescale 1ns/10ps
module lps_seq_element #(
  parameter int ADDR_W = lps_pkg::LPS_ADDR_W
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              lut_even_out,
  input  wire logic              lut_odd_out,
  input  wire logic              logic_unit_generic_clock,
  output logic                   even_table_enable,
  output logic                   reset_request,
  output logic                   seq_out
);

  lps_pkg::lps_state_s state_r;
  lps_pkg::lps_state_s state_nxt;
  logic                gclk_rise;
  logic                q_core;
  logic                access;
  logic                wr_en;

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a == lps_pkg::LPS_OFS_SEQ_CTRL) || (a == lps_pkg::LPS_OFS_TBL_CTRL) ||
                (a == lps_pkg::LPS_OFS_STATUS);
  endfunction : is_mapped

  function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a, input lps_pkg::lps_state_s s);
    read_word = lps_pkg::LPS_ZERO_WORD;
    if (a == lps_pkg::LPS_OFS_SEQ_CTRL)
    begin
      read_word[lps_pkg::LPS_SEL_MSB:lps_pkg::LPS_SEL_LSB] = s.mode;
    end
    else if (a == lps_pkg::LPS_OFS_TBL_CTRL)
    begin
      read_word[lps_pkg::LPS_EN_BIT] = s.even_en;
    end
    else if (a == lps_pkg::LPS_OFS_STATUS)
    begin
      read_word[lps_pkg::LPS_STAT_Q_BIT]   = s.q & s.even_en;
      read_word[lps_pkg::LPS_STAT_RST_BIT] = s.rst_req;
      read_word[lps_pkg::LPS_STAT_EN_BIT]  = s.even_en;
    end
  endfunction : read_word

  // Zero wait states: the access phase always completes
  assign access  = psel & penable;
  assign pready  = access;
  assign pslverr = access & ~is_mapped(paddr);
  assign wr_en   = access & pwrite & is_mapped(paddr);
  assign prdata  = state_r.prdata;

  assign gclk_rise         = logic_unit_generic_clock & ~state_r.gclk_d;
  assign even_table_enable = state_r.even_en;
  assign reset_request     = state_r.rst_req;
  // Gating by the enable flop makes the clear visible in the same cycle the enable drops
  assign seq_out           = state_r.q & state_r.even_en;

  lps_seq_next u_next (
    .mode     (state_r.mode),
    .even_in  (lut_even_out),
    .odd_in   (lut_odd_out),
    .q        (state_r.q),
    .clk_rise (gclk_rise),
    .clear    (state_r.rst_req | ~state_r.even_en),
    .q_nxt    (q_core)
  );

  always_comb
  begin
    state_nxt        = state_r;
    state_nxt.gclk_d = logic_unit_generic_clock;
    state_nxt.q      = q_core;
    if (psel && !penable && !pwrite)
    begin
      // Read data is captured in setup so the output comes from a flop
      state_nxt.prdata = read_word(paddr, state_r);
    end
    if (wr_en && paddr == lps_pkg::LPS_OFS_SEQ_CTRL)
    begin
      // Software is expected to hold the even table disabled here
      state_nxt.mode = lps_pkg::lps_mode_e'(pwdata[lps_pkg::LPS_SEL_MSB:lps_pkg::LPS_SEL_LSB]);
    end
    if (wr_en && paddr == lps_pkg::LPS_OFS_TBL_CTRL)
    begin
      state_nxt.even_en = pwdata[lps_pkg::LPS_EN_BIT];
    end
    // One-cycle reset pulse on the enable falling
    state_nxt.rst_req = state_r.even_en & ~state_nxt.even_en;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      state_r <= lps_pkg::LPS_STATE_RST;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  logic ff_mode;
  logic run;
  assign ff_mode = (state_r.mode == lps_pkg::LPS_MODE_DFF) || (state_r.mode == lps_pkg::LPS_MODE_JK);
  assign run     = state_r.even_en & ~state_r.rst_req;

  a_mode_write_back: assert property (
    (wr_en && paddr == lps_pkg::LPS_OFS_SEQ_CTRL)
    |=> (state_r.mode == $past(pwdata[lps_pkg::LPS_SEL_MSB:lps_pkg::LPS_SEL_LSB])))
    else $error("selected sequential type does not match the written value");

  a_dff_load_data: assert property (
    (state_r.mode == lps_pkg::LPS_MODE_DFF && run && gclk_rise && lut_odd_out)
    |=> (state_r.q == $past(lut_even_out)))
    else $error("flip-flop did not load the even table output");

  a_dff_gate_hold: assert property (
    (state_r.mode == lps_pkg::LPS_MODE_DFF && run && !lut_odd_out) |=> $stable(state_r.q))
    else $error("flip-flop changed with gate low");

  a_disable_clears: assert property (
    !state_r.even_en |-> (seq_out == 1'b0) ##1 (state_r.q == 1'b0))
    else $error("output not cleared while even table disabled");

  a_reset_one_cycle: assert property (
    $fell(state_r.even_en) |-> state_r.rst_req ##1 !state_r.rst_req)
    else $error("reset request not exactly one cycle");

  a_edge_only_update: assert property (
    (ff_mode && run && !gclk_rise) |=> $stable(state_r.q))
    else $error("flip-flop output changed without a generic clock edge");

  a_jk_set_clear: assert property (
    (state_r.mode == lps_pkg::LPS_MODE_JK && run && gclk_rise && (lut_even_out != lut_odd_out))
    |=> (state_r.q == $past(lut_even_out)))
    else $error("JK set or clear taken from the wrong input");

  a_jk_toggle_hold: assert property (
    (state_r.mode == lps_pkg::LPS_MODE_JK && run && gclk_rise && (lut_even_out == lut_odd_out))
    |=> (state_r.q == ($past(state_r.q) ^ $past(lut_even_out))))
    else $error("JK toggle or hold wrong");

  // Latch and RS modes track their inputs at ref_clk rate, one cycle behind
  a_latch_follow: assert property (
    (state_r.mode == lps_pkg::LPS_MODE_DLATCH && run && lut_odd_out)
    |=> (state_r.q == $past(lut_even_out)))
    else $error("gated latch did not follow the even table output");

  a_latch_hold: assert property (
    (state_r.mode == lps_pkg::LPS_MODE_DLATCH && run && !lut_odd_out) |=> $stable(state_r.q))
    else $error("gated latch changed with gate low");

  a_rs_set: assert property (
    (state_r.mode == lps_pkg::LPS_MODE_RS && run && lut_even_out && !lut_odd_out)
    |=> state_r.q)
    else $error("RS latch did not set");

  a_rs_reset: assert property (
    (state_r.mode == lps_pkg::LPS_MODE_RS && run && lut_odd_out && !lut_even_out)
    |=> !state_r.q)
    else $error("RS latch did not reset");

  // Both inputs high is held on purpose rather than resolved toward either value
  a_rs_both_hold: assert property (
    (state_r.mode == lps_pkg::LPS_MODE_RS && run && lut_even_out && lut_odd_out)
    |=> $stable(state_r.q))
    else $error("RS latch changed with both inputs high");

  a_mode_only_written: assert property (
    !(wr_en && paddr == lps_pkg::LPS_OFS_SEQ_CTRL) |=> $stable(state_r.mode))
    else $error("sequential type changed without a write");

  a_bad_write_ignored: assert property (
    (access && pwrite && !is_mapped(paddr))
    |=> ($stable(state_r.mode) && $stable(state_r.even_en)))
    else $error("write to an unmapped address changed a register");

  a_enable_write: assert property (
    (wr_en && paddr == lps_pkg::LPS_OFS_TBL_CTRL)
    |=> (state_r.even_en == $past(pwdata[lps_pkg::LPS_EN_BIT])))
    else $error("even table enable does not match the written value");

  a_read_capture: assert property (
    (psel && !penable && !pwrite && paddr == lps_pkg::LPS_OFS_SEQ_CTRL)
    |=> (prdata[lps_pkg::LPS_SEL_MSB:lps_pkg::LPS_SEL_LSB] == $past(state_r.mode)))
    else $error("read data does not hold the selected sequential type");

  a_status_capture: assert property (
    (psel && !penable && !pwrite && paddr == lps_pkg::LPS_OFS_STATUS)
    |=> (prdata[lps_pkg::LPS_STAT_Q_BIT] == $past(seq_out)))
    else $error("status read data does not hold the element output");

  // A pulse with no falling enable behind it would clear the element spuriously
  a_reset_cause: assert property (
    state_r.rst_req |-> ($past(state_r.even_en) && !state_r.even_en))
    else $error("reset request without a falling even table enable");

  c_dff_set:   cover property (state_r.mode == lps_pkg::LPS_MODE_DFF && run && gclk_rise && lut_odd_out ##1 seq_out);
  c_jk_toggle: cover property (state_r.mode == lps_pkg::LPS_MODE_JK && run && gclk_rise &&
                               lut_even_out && lut_odd_out);
  c_disable:   cover property (seq_out ##1 state_r.rst_req);
  c_bad_addr:  cover property (pslverr);
  c_rs_set:    cover property (state_r.mode == lps_pkg::LPS_MODE_RS && run && lut_even_out && !lut_odd_out);

endmodule : lps_seq_element

// >>> test/lps_pair_model.sv
// Purpose: Model of the lookup-table pair and generic clock feeding the element
// Assumes: Bench sets the wanted levels; the model presents them after one edge
// Notes:   Generic clock is pulsed on request so each rising edge is deliberate
`timescale 1ns/10ps
module lps_pair_model (
  input  wire logic ref_clk,
  input  wire logic even_val,
  input  wire logic odd_val,
  input  wire logic tick,
  output logic      lut_even_out,
  output logic      lut_odd_out,
  output logic      logic_unit_generic_clock
);
  // Registered so the tables never change in the element's sampling step
  always_ff @(posedge ref_clk)
  begin
    lut_even_out             <= even_val;
    lut_odd_out              <= odd_val;
    logic_unit_generic_clock <= tick;
  end
endmodule : lps_pair_model

// >>> test/tb_top.sv
// Purpose: Self-checking bench for the pair sequential element
// Assumes: Zero-wait APB slave; four cycles settle any generic clock edge
// Notes:   Each scenario is its own task and judges its own results
`timescale 1ns/10ps
module tb_top;
  localparam logic [7:0] SEQ = lps_pkg::LPS_OFS_SEQ_CTRL;
  localparam logic [7:0] TBL = lps_pkg::LPS_OFS_TBL_CTRL;
  localparam logic [7:0] STA = lps_pkg::LPS_OFS_STATUS;
  logic        ref_clk, pready, pslverr, le, lo, gclk, ete, rrq, seq_out, lerr;
  logic        rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ev = 1'b0, od = 1'b0, tk = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  int          err_total = 0, n_checks = 0, cyc = 0;

  lps_seq_element DUT (.ref_clk(ref_clk), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lut_even_out(le), .lut_odd_out(lo), .logic_unit_generic_clock(gclk),
    .even_table_enable(ete), .reset_request(rrq), .seq_out(seq_out));
  lps_pair_model PM (.ref_clk(ref_clk), .even_val(ev), .odd_val(od), .tick(tk),
    .lut_even_out(le), .lut_odd_out(lo), .logic_unit_generic_clock(gclk));

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic test_done;
    if (err_total == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done

  // Whole run needs well under a thousand cycles
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd      = prdata;
    lerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic step(input logic e, input logic o, input logic t);
    @(posedge ref_clk);
    ev <= e;
    od <= o;
    tk <= t;
    @(posedge ref_clk);
    tk <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask : step

  // Even table off around every mode change
  task automatic cfg(input logic [31:0] m);
    apb(1'b1, TBL, 32'h0000_0000);
    apb(1'b1, SEQ, m);
    apb(1'b1, TBL, 32'h0000_0001);
  endtask : cfg

  task automatic t_rst;
    apb(1'b0, STA, 32'h0000_0000);
    chk("status", 32'h0000_0000, rd);
    chk("seq_out", 32'h0000_0000, 32'(seq_out));
  endtask : t_rst

  task automatic t_bad;
    apb(1'b1, 8'hFC, 32'hFFFF_FFFF);
    chk("wr_slverr", 32'h0000_0001, 32'(lerr));
    apb(1'b0, 8'hFC, 32'h0000_0000);
    chk("rd_unmapped", 32'h0000_0000, rd);
    chk("rd_slverr", 32'h0000_0001, 32'(lerr));
    apb(1'b0, SEQ, 32'h0000_0000);
    chk("seq_untouched", 32'h0000_0000, rd);
  endtask : t_bad

  task automatic t_mode;
    for (int i = 3; i >= 0; i--)
    begin
      apb(1'b1, SEQ, 32'(i));
      apb(1'b0, SEQ, 32'h0000_0000);
      chk("mode", 32'(i), rd);
    end
  endtask : t_mode

  task automatic t_dff;
    int k;
    cfg(32'h0000_0000);
    #1;
    chk("ete_on", 32'h0000_0001, 32'(ete));
    step(1'b1, 1'b1, 1'b0);
    chk("dff_no_edge", 32'h0000_0000, 32'(seq_out));
    step(1'b1, 1'b1, 1'b1);
    chk("dff_load1", 32'h0000_0001, 32'(seq_out));
    apb(1'b0, STA, 32'h0000_0000);
    chk("status_run", 32'h0000_0005, rd);
    step(1'b0, 1'b0, 1'b1);
    chk("dff_hold", 32'h0000_0001, 32'(seq_out));
    step(1'b0, 1'b1, 1'b1);
    chk("dff_load0", 32'h0000_0000, 32'(seq_out));
    step(1'b1, 1'b1, 1'b1);
    apb(1'b1, TBL, 32'h0000_0000);
    #1;
    chk("dis_clear", 32'h0000_0000, 32'(seq_out));
    chk("ete_off", 32'h0000_0000, 32'(ete));
    k = 0;
    repeat (4)
    begin
      if (rrq === 1'b1)
        k++;
      @(posedge ref_clk);
      #1;
    end
    chk("rst_req_len", 32'h0000_0001, 32'(k));
    step(1'b1, 1'b1, 1'b1);
    chk("dis_stays", 32'h0000_0000, 32'(seq_out));
  endtask : t_dff

  task automatic t_jk;
    // Each entry is J, K, expected output, starting from a cleared output
    logic [2:0] tab [5] = '{3'b101, 3'b001, 3'b110, 3'b111, 3'b010};
    cfg(32'h0000_0001);
    foreach (tab[i])
    begin
      step(tab[i][2], tab[i][1], 1'b1);
      chk("jk", 32'(tab[i][0]), 32'(seq_out));
    end
  endtask : t_jk

  task automatic t_lat;
    cfg(32'h0000_0002);
    step(1'b1, 1'b1, 1'b0);
    chk("latch_open", 32'h0000_0001, 32'(seq_out));
    step(1'b0, 1'b0, 1'b0);
    chk("latch_hold", 32'h0000_0001, 32'(seq_out));
    cfg(32'h0000_0003);
    step(1'b1, 1'b0, 1'b0);
    chk("rs_set", 32'h0000_0001, 32'(seq_out));
    step(1'b1, 1'b1, 1'b0);
    chk("rs_hold", 32'h0000_0001, 32'(seq_out));
    step(1'b0, 1'b1, 1'b0);
    chk("rs_reset", 32'h0000_0000, 32'(seq_out));
  endtask : t_lat

  // Reset in mid-run with the element set must clear output, enable and type
  task automatic t_rerst;
    step(1'b1, 1'b0, 1'b0);
    chk("rs_before_rst", 32'h0000_0001, 32'(seq_out));
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1;
    chk("rst_seq_out", 32'h0000_0000, 32'(seq_out));
    chk("rst_ete", 32'h0000_0000, 32'(ete));
    apb(1'b0, SEQ, 32'h0000_0000);
    chk("rst_mode", 32'h0000_0000, rd);
  endtask : t_rerst

  initial
  begin
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_rst();
    t_bad();
    t_mode();
    t_dff();
    t_jk();
    t_lat();
    t_rerst();
    test_done();
  end
endmodule : tb_top
